// [rtl/dual_port_ram.sv]
// True dual-port 4096-cell memory with per-port width, enable, write
// enable and synchronous output reset.
// Assumes every input is synchronous to core_clk_in; port clocks are
// sampled levels whose rising edge (after inversion) is the active edge.
`timescale 1ns/1ps

// Behaviour
// RULE1: five aspect ratios over 4096 cells
// RULE2: ports fully independent, no arbitration
// RULE3: disabled port holds output, never writes
// RULE4: clock, enable, write, reset inversion options
// RULE5: output reset clears output, cells untouched
// RULE6: address width follows port aspect ratio
// RULE7: write data as wide as port
// RULE8: output shows cells at last edge
// RULE9: write stores data and mirrors it out
// RULE10: word N occupies bits N*W upward
// RULE11: same-cell access allowed, no lasting damage
// RULE12: user keeps opposite port off written cell
// RULE13: window matters only same cell with write
// RULE14: double write makes cell invalid, mirrors kept
// RULE15: write-read: write good, reader invalid
// RULE16: all port inputs sampled on active edge
// RULE17: enable without write performs a read
// RULE18: other port write leaves held output alone
// RULE19: cells preloaded from sixteen 64-digit slices
// RULE20: slice k fills cells 256k+255 to 256k
// RULE21: missing or short slices load zeros
// RULE22: over-long slice string is rejected
// RULE23: output reset needs enable, beats data
// RULE24: collision-invalid cells and outputs go unknown
module dual_port_ram
  import dual_port_ram_pkg::*;
#(
  parameter int             WIDTH_A   = 16,
  parameter int             WIDTH_B   = 16,
  parameter bit             INV_CLK_A = 1'b0,
  parameter bit             INV_EN_A  = 1'b0,
  parameter bit             INV_WE_A  = 1'b0,
  parameter bit             INV_RST_A = 1'b0,
  parameter bit             INV_CLK_B = 1'b0,
  parameter bit             INV_EN_B  = 1'b0,
  parameter bit             INV_WE_B  = 1'b0,
  parameter bit             INV_RST_B = 1'b0,
  parameter preload_slice_t PRELOAD [SLICE_COUNT] = '{default: '0}
) (
  // Core clock and reset
  input  wire logic                               core_clk_in,
  input  wire logic                               rst_in,
  // Port A controls
  input  wire logic                               port_a_clock_in,
  input  wire logic                               port_a_enable_in,
  input  wire logic                               port_a_write_enable_in,
  input  wire logic                               port_a_out_reset_in,
  // Port A data
  input  wire logic [$clog2(CELL_COUNT/WIDTH_A)-1:0] port_a_addr_in,
  input  wire logic [WIDTH_A-1:0]                 port_a_write_in,
  output logic      [WIDTH_A-1:0]                 port_a_read_out,
  // Port B controls
  input  wire logic                               port_b_clock_in,
  input  wire logic                               port_b_enable_in,
  input  wire logic                               port_b_write_enable_in,
  input  wire logic                               port_b_out_reset_in,
  // Port B data
  input  wire logic [$clog2(CELL_COUNT/WIDTH_B)-1:0] port_b_addr_in,
  input  wire logic [WIDTH_B-1:0]                 port_b_write_in,
  output logic      [WIDTH_B-1:0]                 port_b_read_out
);

  import dual_port_ram_pkg::*;

  // ****************************************************************
  // Configuration checks
  // ****************************************************************
  localparam int PW [PORT_COUNT] = '{WIDTH_A, WIDTH_B};

  for (genvar k = 0; k < SLICE_COUNT; k++) begin : g_chk
    if (PRELOAD[k][SLICE_HELD-1:SLICE_BITS] != '0) begin : g_long
      $error("Preload slice longer than 64 hex digits");  // see RULE22
    end
  end
  for (genvar p = 0; p < PORT_COUNT; p++) begin : g_wchk
    if (PW[p] != 1 && PW[p] != 2 && PW[p] != 4 && PW[p] != 8 &&
        PW[p] != MAX_WIDTH) begin : g_bad
      $error("Port width must be 1, 2, 4, 8 or 16");  // see RULE1
    end
  end

  // Slice k lands on cells 256k+255 down to 256k; short strings zero fill
  function automatic logic [CELL_COUNT-1:0] build_image();
    logic [CELL_COUNT-1:0] img;
    img = '0;
    for (int k = 0; k < SLICE_COUNT; k++) begin
      img[k*SLICE_BITS +: SLICE_BITS] = PRELOAD[k][SLICE_BITS-1:0];
    end
    return img;
  endfunction
  localparam logic [CELL_COUNT-1:0] PRELOAD_IMAGE = build_image();
  // see RULE19 see RULE20 see RULE21

  // ****************************************************************
  // Input decode
  // ****************************************************************
  logic                   lvl_cur [PORT_COUNT];
  logic                   act     [PORT_COUNT];
  logic                   en      [PORT_COUNT];
  logic                   we      [PORT_COUNT];
  logic                   ors     [PORT_COUNT];
  logic [CELL_AW-1:0]     base    [PORT_COUNT];
  logic [MAX_WIDTH-1:0]   din     [PORT_COUNT];
  logic                   lvl_r   [PORT_COUNT];

  always_comb begin
    // Each option is a plain XOR, fixed by parameter
    lvl_cur[0] = port_a_clock_in ^ INV_CLK_A;  // see RULE4
    lvl_cur[1] = port_b_clock_in ^ INV_CLK_B;
    en[0]      = port_a_enable_in ^ INV_EN_A;
    en[1]      = port_b_enable_in ^ INV_EN_B;
    we[0]      = port_a_write_enable_in ^ INV_WE_A;
    we[1]      = port_b_write_enable_in ^ INV_WE_B;
    ors[0]     = port_a_out_reset_in ^ INV_RST_A;
    ors[1]     = port_b_out_reset_in ^ INV_RST_B;
    // Word N starts at cell N*W for either port width
    base[0]    = CELL_AW'(32'(port_a_addr_in) * WIDTH_A);  // see RULE10
    base[1]    = CELL_AW'(32'(port_b_addr_in) * WIDTH_B);  // see RULE6
    din[0]     = MAX_WIDTH'(port_a_write_in);              // see RULE7
    din[1]     = MAX_WIDTH'(port_b_write_in);
    for (int p = 0; p < PORT_COUNT; p++) begin
      // Rising active edge; every other input is taken in this cycle
      act[p] = lvl_cur[p] & ~lvl_r[p];  // see RULE16
    end
  end

  // ****************************************************************
  // Cells, outputs and recent-access records
  // ****************************************************************
  logic [CELL_COUNT-1:0]  mem_r,      mem_nxt;
  logic [MAX_WIDTH-1:0]   out_r [PORT_COUNT];
  logic [MAX_WIDTH-1:0]   out_nxt [PORT_COUNT];
  logic                   lvl_nxt [PORT_COUNT];
  logic [CELL_AW-1:0]     rec_base_r [PORT_COUNT];
  logic [CELL_AW-1:0]     rec_base_nxt [PORT_COUNT];
  logic                   rec_we_r [PORT_COUNT];
  logic                   rec_we_nxt [PORT_COUNT];
  logic [AGE_BITS-1:0]    age_r [PORT_COUNT];
  logic [AGE_BITS-1:0]    age_nxt [PORT_COUNT];

  function automatic logic overlap(input logic [CELL_AW-1:0] b0,
                                   input int w0,
                                   input logic [CELL_AW-1:0] b1,
                                   input int w1);
    return (32'(b0) < 32'(b1) + w1) && (32'(b1) < 32'(b0) + w0);
  endfunction

  always_comb begin
    int q;
    logic now_ov;
    logic rec_ov;
    logic hit_w;
    logic hit_r;
    q      = 0;
    now_ov = 1'b0;
    rec_ov = 1'b0;
    hit_w  = 1'b0;
    hit_r  = 1'b0;
    mem_nxt = mem_r;
    for (int p = 0; p < PORT_COUNT; p++) begin
      lvl_nxt[p]      = lvl_cur[p];
      out_nxt[p]      = out_r[p];
      rec_base_nxt[p] = rec_base_r[p];
      rec_we_nxt[p]   = rec_we_r[p];
      age_nxt[p]      = (32'(age_r[p]) < SETUP_WINDOW_CYC) ?
                        AGE_BITS'(age_r[p] + 1'b1) : age_r[p];
    end
    // Writes first; no arbitration, each port acts on its own edge
    for (int p = 0; p < PORT_COUNT; p++) begin
      if (act[p] && en[p] && we[p]) begin  // see RULE2 see RULE3
        for (int j = 0; j < MAX_WIDTH; j++) begin
          if (j < PW[p]) begin
            mem_nxt[base[p] + CELL_AW'(j)] = din[p][j];  // see RULE9
          end
        end
      end
    end
    // Collisions only for overlapping cells with a write involved
    for (int p = 0; p < PORT_COUNT; p++) begin
      q      = PORT_COUNT - 1 - p;
      now_ov = act[q] && en[q] && overlap(base[p], PW[p], base[q], PW[q]);
      rec_ov = (32'(age_r[q]) < SETUP_WINDOW_CYC) &&
               overlap(base[p], PW[p], rec_base_r[q], PW[q]);
      hit_w  = (now_ov && we[q]) || (rec_ov && rec_we_r[q]);  // see RULE13
      // Our own recent read caught by a write from the far side now
      hit_r  = (32'(age_r[p]) < SETUP_WINDOW_CYC) && !rec_we_r[p] &&
               overlap(rec_base_r[p], PW[p], base[q], PW[q]);
      if (act[p] && en[p]) begin
        rec_base_nxt[p] = base[p];
        rec_we_nxt[p]   = we[p];
        age_nxt[p]      = '0;
        if (we[p] && hit_w) begin
          // Only the doubly written cells go unknown; the rest stay good
          for (int j = 0; j < MAX_WIDTH; j++) begin
            if (j < PW[p] &&
                ((now_ov && we[q] &&
                  overlap(base[p] + CELL_AW'(j), 1, base[q], PW[q])) ||
                 (rec_ov && rec_we_r[q] &&
                  overlap(base[p] + CELL_AW'(j), 1, rec_base_r[q],
                          PW[q])))) begin
              mem_nxt[base[p] + CELL_AW'(j)] = 1'bx;  // see RULE14 see RULE24
            end
          end
        end
        if (ors[p]) begin
          out_nxt[p] = '0;  // see RULE5 see RULE23
        end else if (we[p]) begin
          out_nxt[p] = din[p];  // see RULE9 see RULE14 see RULE15
        end else if (hit_w) begin
          out_nxt[p] = 'x;  // see RULE15 see RULE24
        end else begin
          for (int j = 0; j < MAX_WIDTH; j++) begin
            out_nxt[p][j] = (j < PW[p]) ?
                            mem_r[base[p] + CELL_AW'(j)] : 1'b0;  // see RULE17
          end
        end
      end else if (we[q] && act[q] && en[q] && hit_r) begin
        // A reader caught inside the window loses its data; otherwise a
        // write on the far side never disturbs a held output
        out_nxt[p] = 'x;  // see RULE15 see RULE18 see RULE11
      end
    end
  end

  // Preload acts as the configured content; outputs start cleared
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mem_r <= PRELOAD_IMAGE;  // see RULE19
      for (int p = 0; p < PORT_COUNT; p++) begin
        lvl_r[p]      <= 1'b1;
        out_r[p]      <= '0;
        rec_base_r[p] <= '0;
        rec_we_r[p]   <= 1'b0;
        age_r[p]      <= AGE_BITS'(SETUP_WINDOW_CYC);
      end
    end else begin
      mem_r <= mem_nxt;
      for (int p = 0; p < PORT_COUNT; p++) begin
        lvl_r[p]      <= lvl_nxt[p];
        out_r[p]      <= out_nxt[p];  // see RULE8
        rec_base_r[p] <= rec_base_nxt[p];
        rec_we_r[p]   <= rec_we_nxt[p];
        age_r[p]      <= age_nxt[p];
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign port_a_read_out = out_r[0][WIDTH_A-1:0];
  assign port_b_read_out = out_r[1][WIDTH_B-1:0];

endmodule

// [rtl/dual_port_ram_pkg.sv]
// Shared constants for the true dual-port 4096-cell block memory.
// Assumes one core clock at 250 MHz; port clocks arrive as sampled levels.
package dual_port_ram_pkg;

  // ****************************************************************
  // Cell array geometry
  // ****************************************************************
  localparam int CELL_COUNT   = 4096;
  localparam int CELL_AW      = 12;
  localparam int MAX_WIDTH    = 16;
  localparam int PORT_COUNT   = 2;
  localparam int WIDTH_AW     = 5;

  // ****************************************************************
  // Preload image: sixteen slices of 64 hex digits
  // ****************************************************************
  localparam int SLICE_COUNT  = 16;
  localparam int SLICE_DIGITS = 64;
  localparam int DIGIT_BITS   = 4;
  localparam int SLICE_BITS   = SLICE_DIGITS * DIGIT_BITS;
  // Slices are declared twice as wide so an over-long string is caught
  localparam int SLICE_HELD   = 2 * SLICE_BITS;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CORE_CLK_PS      = 4000;
  localparam int SETUP_WINDOW_PS  = 4000;
  localparam int SETUP_WINDOW_CYC =
    (SETUP_WINDOW_PS + CORE_CLK_PS - 1) / CORE_CLK_PS < 1 ? 1 :
    (SETUP_WINDOW_PS + CORE_CLK_PS - 1) / CORE_CLK_PS;
  localparam int AGE_BITS         = 8;

  typedef logic [SLICE_HELD-1:0] preload_slice_t;

endpackage

// [bench/fabric_port_clock.sv]
// Fabric-side maker of the memory's port clock level.
// Assumes start pulses are one core cycle long and at least 3 cycles apart.
`timescale 1ns/1ps
module fabric_port_clock (
  // Core clock and reset
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  // Request and port clock level
  input  wire logic start_in,
  output logic      port_clock_out
);
  logic clk_nxt;
  // Low for one cycle after a start, so each start makes one rising edge
  always_comb begin
    clk_nxt = !start_in;
  end
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      port_clock_out <= 1'b1;
    end else begin
      port_clock_out <= clk_nxt;
    end
  end
endmodule

// [bench/dual_port_ram_chk.sv]
// Port checker for the dual-port memory, bound to its top module.
// Assumes default inversion options and one core clock domain.
`timescale 1ns/1ps
module dual_port_ram_chk
  import dual_port_ram_pkg::*;
#(parameter int WIDTH_A = 16, parameter int WIDTH_B = 16) (
  // Clock and reset
  input wire logic core_clk_in, rst_in,
  // Port A
  input wire logic port_a_clock_in, port_a_enable_in,
  input wire logic port_a_write_enable_in, port_a_out_reset_in,
  input wire logic [$clog2(CELL_COUNT/WIDTH_A)-1:0] port_a_addr_in,
  input wire logic [WIDTH_A-1:0] port_a_write_in, port_a_read_out,
  // Port B
  input wire logic port_b_clock_in, port_b_enable_in,
  input wire logic port_b_write_enable_in, port_b_out_reset_in,
  input wire logic [$clog2(CELL_COUNT/WIDTH_B)-1:0] port_b_addr_in,
  input wire logic [WIDTH_B-1:0] port_b_write_in, port_b_read_out
);
  logic ca_r, cb_r, sa_r, sb_r;
  wire act_a = port_a_clock_in && !ca_r && port_a_enable_in;
  wire act_b = port_b_clock_in && !cb_r && port_b_enable_in;
  wire wr_a = act_a && port_a_write_enable_in;
  wire wr_b = act_b && port_b_write_enable_in;
  wire rd_a = act_a && !port_a_write_enable_in && !port_a_out_reset_in;
  wire rd_b = act_b && !port_b_write_enable_in && !port_b_out_reset_in;
  // Other port touched memory since our write: read-back not predictable
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      {ca_r, cb_r, sa_r, sb_r} <= 4'hc;
    end else begin
      {ca_r, cb_r} <= {port_a_clock_in, port_b_clock_in};
      sa_r <= act_a || (sa_r && !wr_b);
      sb_r <= act_b || (sb_r && !wr_a);
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_wr_a; wr_a && !act_b; endsequence
  sequence s_wr_b; wr_b && !act_a; endsequence
  sequence s_rd_a;
    rd_a && !sb_r && port_a_addr_in == $past(port_a_addr_in, 4);
  endsequence
  sequence s_rd_b;
    rd_b && !sa_r && port_b_addr_in == $past(port_b_addr_in, 4);
  endsequence
  a_hold_a: assert property (!act_a |=> $stable(port_a_read_out))
    else $error("port A output moved while idle");
  b_hold_a: assert property (!act_b |=> $stable(port_b_read_out))
    else $error("port B output moved while idle");
  a_mirror_a: assert property (wr_a && !port_a_out_reset_in |=>
    port_a_read_out == $past(port_a_write_in))
    else $error("port A write not mirrored");
  b_mirror_a: assert property (wr_b && !port_b_out_reset_in |=>
    port_b_read_out == $past(port_b_write_in))
    else $error("port B write not mirrored");
  a_clear_a: assert property (act_a && port_a_out_reset_in |=>
    port_a_read_out == '0) else $error("port A output not cleared");
  b_clear_a: assert property (act_b && port_b_out_reset_in |=>
    port_b_read_out == '0) else $error("port B output not cleared");
  a_readback_a: assert property (s_wr_a ##4 s_rd_a |=>
    port_a_read_out == $past(port_a_write_in, 5))
    else $error("port A read-back differs");
  b_readback_a: assert property (s_wr_b ##4 s_rd_b |=>
    port_b_read_out == $past(port_b_write_in, 5))
    else $error("port B read-back differs");
endmodule
bind dual_port_ram dual_port_ram_chk #(.WIDTH_A(WIDTH_A), .WIDTH_B(WIDTH_B))
  u_chk (.core_clk_in, .rst_in, .port_a_clock_in, .port_a_enable_in,
  .port_a_write_enable_in, .port_a_out_reset_in, .port_a_addr_in,
  .port_a_write_in, .port_a_read_out, .port_b_clock_in, .port_b_enable_in,
  .port_b_write_enable_in, .port_b_out_reset_in, .port_b_addr_in,
  .port_b_write_in, .port_b_read_out);

// [bench/tb.sv]
// Self-checking bench for the dual-port memory, port A 16 wide, B 4 wide.
// Assumes the fabric clock maker gives both ports one edge per start.
`timescale 1ns/1ps
module tb;
  import dual_port_ram_pkg::*;
  localparam preload_slice_t PRE [SLICE_COUNT] =
    '{0: 512'h0123456789abcdef, 15: {256'h0, 4'ha, 252'h0}, default: '0};
  logic core_clk_in, rst_in, st, pclk, en_a, we_a, clr_a, en_b, we_b, clr_b;
  logic [7:0] addr_a;
  logic [15:0] din_a, q_a, ea;
  logic [9:0] addr_b;
  logic [3:0] din_b, q_b, eb;
  logic [CELL_COUNT-1:0] mem;
  int n_errors, checked, seed, r;
  fabric_port_clock u_clk (.core_clk_in, .rst_in, .start_in(st),
    .port_clock_out(pclk));
  dual_port_ram #(.WIDTH_A(16), .WIDTH_B(4), .PRELOAD(PRE)) u_dut (
    .core_clk_in, .rst_in, .port_a_clock_in(pclk), .port_a_enable_in(en_a),
    .port_a_write_enable_in(we_a), .port_a_out_reset_in(clr_a),
    .port_a_addr_in(addr_a), .port_a_write_in(din_a), .port_a_read_out(q_a),
    .port_b_clock_in(pclk), .port_b_enable_in(en_b),
    .port_b_write_enable_in(we_b), .port_b_out_reset_in(clr_b),
    .port_b_addr_in(addr_b), .port_b_write_in(din_b), .port_b_read_out(q_b));
  task cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task finish_test;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One port edge on both ports; controls are {enable, write, clear}
  task go(input logic [2:0] ca, input logic [7:0] aa, input logic [15:0] da,
          input logic [2:0] cb, input logic [9:0] ab, input logic [3:0] db,
          input bit hit);
    @(posedge core_clk_in);
    {en_a, we_a, clr_a, addr_a, din_a} <= {ca, aa, da};
    {en_b, we_b, clr_b, addr_b, din_b} <= {cb, ab, db};
    st <= 1'b1;
    @(posedge core_clk_in);
    st <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    #1;
    if (ca[2]) ea = ca[0] ? 16'h0 : ca[1] ? da : mem[aa*16 +: 16];
    if (cb[2]) eb = cb[0] ? 4'h0 : cb[1] ? db : mem[ab*4 +: 4];
    if (hit && cb[2] && !cb[1]) eb = 'x;
    if (ca[2] && ca[1]) mem[aa*16 +: 16] = da;
    if (cb[2] && cb[1]) mem[ab*4 +: 4] = (hit && ca[1]) ? 'x : db;
    cmp("port_a_read_out", ea, q_a);
    cmp("port_b_read_out", {12'h0, eb}, {12'h0, q_b});
  endtask
  initial begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end
  initial begin
    repeat (20000) @(posedge core_clk_in);
    n_errors++;
    finish_test;
  end
  initial begin
    {rst_in, st, en_a, we_a, clr_a, en_b, we_b, clr_b} = 8'h80;
    {addr_a, din_a, addr_b, din_b, ea, eb} = '0;
    {n_errors, checked, seed} = {32'h0, 32'h0, 32'h2f5d};
    for (int k = 0; k < SLICE_COUNT; k++) mem[k*256 +: 256] = PRE[k][255:0];
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'b0;
    go(3'b100, 8'd0, 16'h0, 3'b100, 10'd1023, 4'h0, 0);
    go(3'b110, 8'd5, 16'hbeef, 3'b000, 10'd0, 4'h0, 0);
    for (int j = 0; j < 4; j++) go(3'b0, 8'd0, 16'h0, 3'b100, 10'(20 + j), 4'h0, 0);
    go(3'b110, 8'd5, 16'h0f0f, 3'b000, 10'd0, 4'h0, 0);
    go(3'b111, 8'd6, 16'h1234, 3'b000, 10'd0, 4'h0, 0);
    go(3'b100, 8'd6, 16'h0, 3'b011, 10'd24, 4'h7, 0);
    go(3'b110, 8'd3, 16'haaaa, 3'b110, 10'd12, 4'h5, 1);
    go(3'b110, 8'd3, 16'h5a5a, 3'b000, 10'd0, 4'h0, 0);
    go(3'b110, 8'd9, 16'h3c3c, 3'b100, 10'd36, 4'h0, 1);
    go(3'b100, 8'd9, 16'h0, 3'b100, 10'd36, 4'h0, 0);
    repeat (80) begin
      r = $random(seed);
      go({r[0] | r[1], r[2], r[3] & r[4]}, {5'h0, r[7:5]}, r[31:16],
         {r[8] | r[9], r[10], r[11] & r[12]}, {7'h40, r[15:13]}, r[19:16],
         0);
    end
    finish_test;
  end
endmodule
